// ==== hdl/drive_serial_port_config.sv ====
// serial port setup and supervision: line format, station filter, reply delay,
// comms watchdog and error reaction, all set by the local cpu over apb
// assumes uart/protocol logic on the same clock reports frames and network write attempts
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ps

module drive_serial_port_config
    import drive_serial_port_config_pkg::*;
#(
    parameter int WDOG_TICK_CYC  = WDOG_STEP_CYC,
    parameter int REPLY_TICK_CYC = REPLY_STEP_CYC
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        netCfgWrite,
    input  wire logic        rxFrameDone,
    input  wire logic        rxFrameOk,
    input  wire logic [7:0]  rxFrameAddr,
    output logic             bitTick,
    output line_cfg_t        lineCfg,
    output logic             frameForUs,
    output logic             replyGo,
    output logic             commErr,
    output logic             tripReq,
    output logic             decelReq,
    output logic             coastReq,
    output logic             irq
);

    // ------------------------------------------------------------------
    // apb slave and configuration registers
    // ------------------------------------------------------------------
    line_cfg_t              line_q, line_d;
    logic      [7:0]        station_q, station_d;
    err_resp_t              errSel_q, errSel_d;
    logic      [13:0]       wdPeriod_q, wdPeriod_d;
    logic      [9:0]        replyDly_q, replyDly_d;
    logic [NUM_EVENTS-1:0]  status_q, status_d, mask_q, mask_d, events;
    logic      [31:0]       prdata_d;
    logic                   pready_d, pslverr_d, irq_d;
    logic                   wrEn, mapped;

    assign wrEn   = psel & penable & pready & pwrite;
    assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_STATE);

    always_comb begin
        line_d     = line_q;
        station_d  = station_q;
        errSel_d   = errSel_q;
        wdPeriod_d = wdPeriod_q;
        replyDly_d = replyDly_q;
        mask_d     = mask_q;
        status_d   = status_q;
        // only the local apb port reaches these; out-of-range values are dropped
        if (wrEn) begin
            case (paddr)
                OFS_LINE: begin
                    if (pwdata[3:0] >= BAUD_MIN && pwdata[3:0] <= BAUD_MAX &&
                        pwdata[5:4] <= PAR_MAX &&
                        (pwdata[7:6] == STOP_ONE || pwdata[7:6] == STOP_TWO))
                        line_d = '{baudSel: pwdata[3:0], parity: pwdata[5:4], stopSel: pwdata[7:6]};
                end
                OFS_STATION: begin
                    if (pwdata[7:0] >= STATION_MIN && pwdata[7:0] <= STATION_MAX)
                        station_d = pwdata[7:0];
                end
                OFS_ERRSEL: begin
                    if (pwdata[2:0] <= ERR_DECEL_STOP)
                        errSel_d = err_resp_t'(pwdata[2:0]);
                end
                OFS_WDOG: begin
                    if (pwdata[13:0] <= WDOG_MAX)
                        wdPeriod_d = pwdata[13:0];
                end
                OFS_REPLY: begin
                    if (pwdata[9:0] <= REPLY_MAX)
                        replyDly_d = pwdata[9:0];
                end
                OFS_STATUS: status_d = status_q & ~pwdata[NUM_EVENTS-1:0];
                OFS_MASK:   mask_d = pwdata[NUM_EVENTS-1:0];
                default: ;
            endcase
        end
        // a fresh event beats a clear in the same cycle
        status_d = status_d | events;
        irq_d    = |(status_d & mask_d);
        // one wait state: read data is fetched in the first access cycle
        pready_d  = psel & penable & ~pready;
        pslverr_d = psel & penable & ~pready & ~mapped;
        prdata_d  = prdata;
        if (psel & penable & ~pready) begin
            case (paddr)
                OFS_LINE:    prdata_d = {24'h000000, line_q.stopSel, line_q.parity, line_q.baudSel};
                OFS_STATION: prdata_d = {24'h000000, station_q};
                OFS_ERRSEL:  prdata_d = {29'h00000000, errSel_q};
                OFS_WDOG:    prdata_d = {18'h00000, wdPeriod_q};
                OFS_REPLY:   prdata_d = {22'h000000, replyDly_q};
                OFS_STATUS:  prdata_d = {28'h0000000, status_q};
                OFS_MASK:    prdata_d = {28'h0000000, mask_q};
                OFS_STATE:   prdata_d = {26'h0000000, replyGo, commErr, tripReq,
                                         decelReq, coastReq, frameForUs};
                default:     prdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_q     <= LINE_RST;
            station_q  <= STATION_RST;
            errSel_q   <= ERR_IGNORE;
            wdPeriod_q <= WDOG_RST;
            replyDly_q <= REPLY_RST;
            status_q   <= '0;
            mask_q     <= '0;
            prdata     <= 32'h00000000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            irq        <= 1'b0;
        end else begin
            line_q     <= line_d;
            station_q  <= station_d;
            errSel_q   <= errSel_d;
            wdPeriod_q <= wdPeriod_d;
            replyDly_q <= replyDly_d;
            status_q   <= status_d;
            mask_q     <= mask_d;
            prdata     <= prdata_d;
            pready     <= pready_d;
            pslverr    <= pslverr_d;
            irq        <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // line format and oversample tick, shared by panel and network
    // ------------------------------------------------------------------
    logic [11:0] baudCnt_q, baudCnt_d;
    logic        bitTick_d;

    always_comb begin
        bitTick_d = 1'b0;
        baudCnt_d = baudCnt_q + 12'h001;
        // a rate change restarts the divider so no short tick appears
        if (line_d.baudSel != line_q.baudSel) begin
            baudCnt_d = 12'h000;
        end else if (baudCnt_q >= baud_div(line_q.baudSel) - 12'h001) begin
            baudCnt_d = 12'h000;
            bitTick_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            baudCnt_q <= 12'h000;
            bitTick   <= 1'b0;
            lineCfg   <= LINE_RST;
        end else begin
            baudCnt_q <= baudCnt_d;
            bitTick   <= bitTick_d;
            lineCfg   <= line_q;
        end
    end

    // ------------------------------------------------------------------
    // station filter and reply delay
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RP_IDLE = 2'b00,
        RP_WAIT = 2'b01
    } reply_state_t;

    reply_state_t rpState_q, rpState_d;
    logic [9:0]   dlyCnt_q, dlyCnt_d;
    logic [19:0]  msPre_q, msPre_d;
    logic         goodFrame, forUsEv, replyEv, msTick;

    assign goodFrame = rxFrameDone & rxFrameOk;
    assign forUsEv   = goodFrame && (rxFrameAddr == station_q);
    assign msTick    = (msPre_q == 20'(REPLY_TICK_CYC - 1));

    always_comb begin
        rpState_d = rpState_q;
        dlyCnt_d  = dlyCnt_q;
        msPre_d   = msTick ? 20'h00000 : msPre_q + 20'h00001;
        replyEv   = 1'b0;
        if (forUsEv) begin
            // a new frame for us restarts the wait from its full length
            rpState_d = RP_WAIT;
            dlyCnt_d  = replyDly_q;
            msPre_d   = 20'h00000;
        end else begin
            case (rpState_q)
                RP_IDLE: ;
                RP_WAIT: begin
                    if (dlyCnt_q == 10'h000) begin
                        replyEv   = 1'b1;
                        rpState_d = RP_IDLE;
                    end else if (msTick) begin
                        dlyCnt_d = dlyCnt_q - 10'h001;
                    end
                end
                default: rpState_d = RP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rpState_q  <= RP_IDLE;
            dlyCnt_q   <= 10'h000;
            msPre_q    <= 20'h00000;
            frameForUs <= 1'b0;
            replyGo    <= 1'b0;
        end else begin
            rpState_q  <= rpState_d;
            dlyCnt_q   <= dlyCnt_d;
            msPre_q    <= msPre_d;
            frameForUs <= forUsEv;
            replyGo    <= replyEv;
        end
    end

    // ------------------------------------------------------------------
    // watchdog and error reaction
    // ------------------------------------------------------------------
    logic [21:0] wdPre_q, wdPre_d;
    logic [13:0] wdCnt_q, wdCnt_d;
    logic        commErr_d, timeoutEv, wdTick;
    logic        tripReq_d, decelReq_d, coastReq_d;

    assign wdTick = (wdPre_q == 22'(WDOG_TICK_CYC - 1));

    always_comb begin
        wdPre_d   = wdTick ? 22'h000000 : wdPre_q + 22'h000001;
        wdCnt_d   = wdCnt_q;
        commErr_d = commErr;
        timeoutEv = 1'b0;
        if (goodFrame) begin
            wdPre_d   = 22'h000000;
            wdCnt_d   = 14'h0000;
            commErr_d = 1'b0;
        end else if (wdPeriod_q != 14'h0000 && !commErr && wdTick) begin
            wdCnt_d = wdCnt_q + 14'h0001;
            if (wdCnt_d >= wdPeriod_q) begin
                timeoutEv = 1'b1;
                commErr_d = 1'b1;
            end
        end
        // the error level stays until a good frame; the drive reacts to it
        tripReq_d  = commErr_d && (errSel_q == ERR_TRIP || errSel_q == ERR_DECEL_TRIP);
        decelReq_d = commErr_d && (errSel_q == ERR_DECEL_TRIP || errSel_q == ERR_DECEL_STOP);
        coastReq_d = commErr_d && (errSel_q == ERR_FREE_RUN);
    end

    assign events = {replyEv, forUsEv, netCfgWrite, timeoutEv};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wdPre_q  <= 22'h000000;
            wdCnt_q  <= 14'h0000;
            commErr  <= 1'b0;
            tripReq  <= 1'b0;
            decelReq <= 1'b0;
            coastReq <= 1'b0;
        end else begin
            wdPre_q  <= wdPre_d;
            wdCnt_q  <= wdCnt_d;
            commErr  <= commErr_d;
            tripReq  <= tripReq_d;
            decelReq <= decelReq_d;
            coastReq <= coastReq_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence seqForUsZero;
        forUsEv && replyDly_q == 10'h000;
    endsequence

    sequence seqReplyPulse;
        !replyGo ##1 replyGo;
    endsequence

    chk_net_write_refused: assert property (@(posedge clk) disable iff (!rstn)
        netCfgWrite && !wrEn |=> $stable(line_q) && $stable(station_q) && $stable(wdPeriod_q))
        else $error("network write changed a setting");

    chk_line_legal: assert property (@(posedge clk) disable iff (!rstn)
        lineCfg.baudSel >= BAUD_MIN && lineCfg.baudSel <= BAUD_MAX && lineCfg.parity <= PAR_MAX &&
        (lineCfg.stopSel == STOP_ONE || lineCfg.stopSel == STOP_TWO))
        else $error("line format out of range");

    chk_station_match: assert property (@(posedge clk) disable iff (!rstn)
        goodFrame && rxFrameAddr != station_q |=> !frameForUs)
        else $error("frame for another station accepted");

    chk_station_range: assert property (@(posedge clk) disable iff (!rstn)
        station_q >= STATION_MIN && station_q <= STATION_MAX)
        else $error("station address out of range");

    chk_reply_zero: assert property (@(posedge clk) disable iff (!rstn)
        seqForUsZero ##1 !forUsEv |-> seqReplyPulse)
        else $error("zero delay reply not issued two cycles after frame");

    chk_reply_hold: assert property (@(posedge clk) disable iff (!rstn)
        forUsEv && replyDly_q != 10'h000 |=> !replyGo [*2])
        else $error("reply issued before its delay");

    chk_wdog_off: assert property (@(posedge clk) disable iff (!rstn)
        wdPeriod_q == 14'h0000 && !commErr |=> !commErr)
        else $error("disabled watchdog raised an error");

    chk_good_clears: assert property (@(posedge clk) disable iff (!rstn)
        goodFrame |=> !commErr ##0 wdCnt_q == 14'h0000)
        else $error("good frame did not restart watchdog");

    chk_err_ignore: assert property (@(posedge clk) disable iff (!rstn)
        (errSel_q == ERR_IGNORE) [*2] |-> !tripReq && !decelReq && !coastReq)
        else $error("ignore setting still requested an action");

    chk_err_trip: assert property (@(posedge clk) disable iff (!rstn)
        commErr_d && errSel_q == ERR_TRIP |=> tripReq && !decelReq)
        else $error("trip setting did not trip");

endmodule // drive_serial_port_config

// ==== hdl/drive_serial_port_config_pkg.sv ====
// package: register map, reset values, timing counts and types of the serial port setup block
// assumes a 40 MHz system clock; the uart and protocol engines live outside this block
package drive_serial_port_config_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ         = 40_000_000;
    localparam int OVERSAMPLE     = 16;
    localparam int WDOG_STEP_MS   = 10;
    localparam int REPLY_STEP_MS  = 1;
    localparam int WDOG_STEP_CYC  = CLK_HZ / 1000 * WDOG_STEP_MS;
    localparam int REPLY_STEP_CYC = CLK_HZ / 1000 * REPLY_STEP_MS;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_LINE    = 8'h00;
    localparam logic [7:0] OFS_STATION = 8'h04;
    localparam logic [7:0] OFS_ERRSEL  = 8'h08;
    localparam logic [7:0] OFS_WDOG    = 8'h0C;
    localparam logic [7:0] OFS_REPLY   = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_MASK    = 8'h18;
    localparam logic [7:0] OFS_STATE   = 8'h1C;

    // ------------------------------------------------------------------
    // field limits and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0]  BAUD_MIN      = 4'h3;
    localparam logic [3:0]  BAUD_MAX      = 4'hA;
    localparam logic [3:0]  BAUD_RST      = 4'h5;
    localparam logic [1:0]  PAR_MAX       = 2'h2;
    localparam logic [1:0]  PAR_RST       = 2'h0;
    localparam logic [1:0]  STOP_ONE      = 2'h1;
    localparam logic [1:0]  STOP_TWO      = 2'h2;
    localparam logic [7:0]  STATION_MIN   = 8'h01;
    localparam logic [7:0]  STATION_MAX   = 8'hF7;
    localparam logic [7:0]  STATION_RST   = 8'h01;
    localparam logic [13:0] WDOG_MAX      = 14'h270F;
    localparam logic [13:0] WDOG_RST      = 14'h0000;
    localparam logic [9:0]  REPLY_MAX     = 10'h3E8;
    localparam logic [9:0]  REPLY_RST     = 10'h000;
    localparam int          NUM_EVENTS    = 4;
    localparam int          EV_TIMEOUT    = 0;
    localparam int          EV_REFUSED    = 1;
    localparam int          EV_FOR_US     = 2;
    localparam int          EV_REPLY      = 3;

    typedef enum logic [2:0] {
        ERR_TRIP       = 3'h0,
        ERR_DECEL_TRIP = 3'h1,
        ERR_IGNORE     = 3'h2,
        ERR_FREE_RUN   = 3'h3,
        ERR_DECEL_STOP = 3'h4
    } err_resp_t;

    typedef struct packed {
        logic [3:0] baudSel;
        logic [1:0] parity;
        logic [1:0] stopSel;
    } line_cfg_t;

    localparam line_cfg_t LINE_RST = '{baudSel: BAUD_RST, parity: PAR_RST, stopSel: STOP_ONE};

    // clocks per oversample tick, rounded to nearest
    function automatic logic [11:0] baud_div(input logic [3:0] code);
        int rate;
        case (code)
            4'h3:    rate = 2400;
            4'h4:    rate = 4800;
            4'h6:    rate = 19200;
            4'h7:    rate = 38400;
            4'h8:    rate = 57600;
            4'h9:    rate = 76800;
            4'hA:    rate = 115200;
            default: rate = 9600;
        endcase
        return 12'((CLK_HZ + OVERSAMPLE * rate / 2) / (OVERSAMPLE * rate));
    endfunction

endpackage

// ==== verif/frame_source_model.sv ====
// protocol engine stand-in: turns bench requests into frame-end and network-write pulses
// assumes one clock with the block; requests are one-cycle pulses from the bench
`timescale 1ns/1ps

module frame_source_model
    import drive_serial_port_config_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       sendReq,
    input  wire logic       sendOk,
    input  wire logic [7:0] sendAddr,
    input  wire logic       netReq,
    output logic            rxFrameDone,
    output logic            rxFrameOk,
    output logic [7:0]      rxFrameAddr,
    output logic            netCfgWrite
);
    // ------------------------------------------------------------------
    // frame reporting
    // ------------------------------------------------------------------
    // outside a frame end the qualifiers toggle so a stale value is never read as valid
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxFrameDone <= 1'b0;
            rxFrameOk   <= 1'b0;
            rxFrameAddr <= 8'h00;
            netCfgWrite <= 1'b0;
        end else begin
            rxFrameDone <= sendReq;
            rxFrameOk   <= sendReq ? sendOk : ~rxFrameOk;
            rxFrameAddr <= sendReq ? sendAddr : ~rxFrameAddr;
            netCfgWrite <= netReq;
        end
    end
endmodule // frame_source_model

// ==== verif/test_drive_serial_port_config.sv ====
// self-checking bench for the serial port setup block
// assumes the frame source model beside it and shortened tick parameters (20 and 10 cycles)
`timescale 1ns/1ps

module test_drive_serial_port_config
    import drive_serial_port_config_pkg::*;
;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, sendAddr = 8'h00, st;
    logic [31:0] pwdata = 32'h0, prdata, rd, w;
    logic        pready, pslverr, err, sendReq = 1'b0, sendOk = 1'b0, netReq = 1'b0;
    logic        netCfgWrite, rxFrameDone, rxFrameOk, bitTick, frameForUs, replyGo;
    logic        commErr, tripReq, decelReq, coastReq, irq;
    logic [7:0]  rxFrameAddr;
    line_cfg_t   lineCfg;
    int          fails = 0, checked = 0, seed = 32'h9C30D798, n, p, q;

    always #12.5 clk = ~clk;

    drive_serial_port_config #(.WDOG_TICK_CYC(20), .REPLY_TICK_CYC(10)) i_dut (.clk(clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .netCfgWrite(netCfgWrite), .rxFrameDone(rxFrameDone),
        .rxFrameOk(rxFrameOk), .rxFrameAddr(rxFrameAddr), .bitTick(bitTick), .lineCfg(lineCfg),
        .frameForUs(frameForUs), .replyGo(replyGo), .commErr(commErr), .tripReq(tripReq),
        .decelReq(decelReq), .coastReq(coastReq), .irq(irq));

    frame_source_model i_src (.clk(clk), .rstn(rstn), .sendReq(sendReq), .sendOk(sendOk),
        .sendAddr(sendAddr), .netReq(netReq), .rxFrameDone(rxFrameDone), .rxFrameOk(rxFrameOk),
        .rxFrameAddr(rxFrameAddr), .netCfgWrite(netCfgWrite));

    // ------------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------------
    task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmpf(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // an idle edge first, so psel is never dropped and raised in one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        cmpv(rd, exp);
    endtask

    // returns just after the edge at which the block takes the frame
    task automatic frame(input logic [7:0] a, input logic ok);
        @(posedge clk);
        sendReq <= 1'b1;
        sendAddr <= a;
        sendOk <= ok;
        @(posedge clk);
        sendReq <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return replyGo;
            1: return commErr;
            default: return bitTick;
        endcase
    endfunction

    task automatic waitSig(input int k, input int lim);
        n = 0;
        while (pick(k) !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask

    function automatic int expDiv(input int c);
        int rates[8] = '{2400, 4800, 9600, 19200, 38400, 57600, 76800, 115200};
        return (CLK_HZ + 8 * rates[c - 3]) / (16 * rates[c - 3]);
    endfunction

    // {trip, decel, coast}; decel-trip raises trip in the same cycle as decel, but only its decel and coast are looked at
    function automatic logic [2:0] react(input int c);
        case (c)
            0: return 3'b100;
            1: return 3'b010;
            3: return 3'b001;
            4: return 3'b010;
            default: return 3'b000;
        endcase
    endfunction

    task automatic end_of_test;
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1 cmpv(32'(lineCfg), 32'h51);
        rdc(OFS_LINE, 32'h45);
        rdc(OFS_STATION, 32'h1);
        rdc(OFS_ERRSEL, 32'h2);
        rdc(OFS_WDOG, 32'h0);
        rdc(OFS_REPLY, 32'h0);
        cmpf(err, 1'b0);
        rdc(8'h20, 32'h0);
        cmpf(err, 1'b1);
        for (int c = 3; c <= 10; c++) begin
            p = $unsigned($random(seed)) % 3;
            q = 1 + $unsigned($random(seed)) % 2;
            w = 32'(c) | (32'(p) << 4) | (32'(q) << 6);
            wr32(OFS_LINE, w);
            rdc(OFS_LINE, w);
            @(posedge clk);
            #1 cmpv(32'(lineCfg), (32'(c) << 4) | (32'(p) << 2) | 32'(q));
            waitSig(2, 3000);
            @(posedge clk);
            #1 waitSig(2, 3000);
            cmpv(n + 1, expDiv(c));
        end
        wr32(OFS_LINE, 32'hAA);
        for (int i = 0; i < 4; i++) begin
            wr32(OFS_LINE, i == 0 ? 32'h3A : i == 1 ? 32'h42 : i == 2 ? 32'hCA : 32'h4B);
            rdc(OFS_LINE, 32'hAA);
        end
        wr32(OFS_STATUS, 32'hF);
        @(posedge clk) netReq <= 1'b1;
        @(posedge clk) netReq <= 1'b0;
        rdc(OFS_LINE, 32'hAA);
        rdc(OFS_STATUS, 32'h2);
        for (int i = 0; i < 2; i++) begin
            st = i ? 8'hF7 : 8'(1 + $unsigned($random(seed)) % 247);
            wr32(OFS_STATION, 32'(st));
            rdc(OFS_STATION, 32'(st));
            frame(st, 1'b1);
            cmpf(frameForUs, 1'b1);
            frame(st ^ 8'h80, 1'b1);
            cmpf(frameForUs, 1'b0);
            frame(st, 1'b0);
            cmpf(frameForUs, 1'b0);
        end
        wr32(OFS_STATION, 32'h0);
        wr32(OFS_STATION, 32'hF8);
        rdc(OFS_STATION, 32'hF7);
        wr32(OFS_REPLY, 32'd1000);
        wr32(OFS_REPLY, 32'd1001);
        rdc(OFS_REPLY, 32'd1000);
        for (int d = 0; d < 4; d += 3) begin
            wr32(OFS_REPLY, 32'(d));
            frame(st, 1'b1);
            waitSig(0, 200);
            cmpf(d == 0 ? n == 1 : (n >= d * 10 && n <= d * 10 + 3), 1'b1);
        end
        wr32(OFS_STATUS, 32'hF);
        wr32(OFS_MASK, 32'h4);
        frame(st, 1'b1);
        repeat (3) @(posedge clk);
        #1 cmpf(irq, 1'b1);
        wr32(OFS_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        #1 cmpf(irq, 1'b0);
        wr32(OFS_MASK, 32'h0);
        frame(st, 1'b1);
        repeat (3) @(posedge clk);
        #1 cmpf(irq, 1'b0);
        wr32(OFS_WDOG, 32'd9999);
        wr32(OFS_WDOG, 32'd10000);
        rdc(OFS_WDOG, 32'd9999);
        wr32(OFS_WDOG, 32'd2);
        for (int c = 0; c < 5; c++) begin
            wr32(OFS_ERRSEL, 32'(c));
            rdc(OFS_ERRSEL, 32'(c));
            frame(st, 1'b1);
            waitSig(1, 200);
            cmpf(n >= 39 && n <= 43, 1'b1);
            cmpv(32'({tripReq, decelReq, coastReq} & (c == 1 ? 3'b011 : 3'b111)), 32'(react(c)));
            apb(1'b0, OFS_STATE, 32'h0);
            cmpv(rd & (c == 1 ? 32'h37 : 32'h3F), 32'h10 | (32'(react(c)) << 1));
            apb(1'b0, OFS_STATUS, 32'h0);
            cmpv(rd & 32'h1, 32'h1);
            wr32(OFS_STATUS, 32'h1);
            frame(st ^ 8'h80, 1'b1);
            @(posedge clk);
            #1 cmpf(commErr, 1'b0);
        end
        wr32(OFS_WDOG, 32'd0);
        wr32(OFS_ERRSEL, 32'd5);
        rdc(OFS_ERRSEL, 32'd4);
        frame(st, 1'b1);
        repeat (100) @(posedge clk);
        #1 cmpf(commErr, 1'b0);
        end_of_test;
    end
endmodule // test_drive_serial_port_config
